/* File: test/cpu_model.sv */
// cpu core model: issues program-memory loads and stores toward the readout block
`timescale 1ns/10ps
module cpu_model (
	input wire logic aclk, // system clock
	output logic load_req, // load strobe
	output logic [15:0] load_ptr, // address pointer
	output logic [7:0] flash_rdata, // flash byte at the pointer
	output logic spm_req, // store strobe
	output logic [7:0] spm_wdata // store data byte
);
	// ====================
	// state
	logic [7:0] last_flash; // flash byte of the latest load
	// idle levels at time zero
	initial begin
		{load_req, spm_req} = 2'h0;
		{load_ptr, flash_rdata, spm_wdata} = '0;
	end
	// flash contents: fixed scramble of the pointer
	function automatic logic [7:0] flash_of(input logic [15:0] p);
		return p[7:0] ^ p[15:8] ^ 8'hC3;
	endfunction
	// one load; the caller picks the cycle, inside or after the redirect window
	task automatic load(input logic [15:0] p);
		last_flash = flash_of(p);
		load_req <= 1'b1;
		load_ptr <= p;
		flash_rdata <= last_flash;
		@(posedge aclk);
		load_req <= 1'b0;
		load_ptr <= ~p; // released pointer and data no longer hold their values
		flash_rdata <= ~last_flash;
	endtask
	// one store; the caller picks the cycle, one store runs during an eeprom write
	task automatic store(input logic [7:0] d);
		spm_req <= 1'b1;
		spm_wdata <= d;
		@(posedge aclk);
		spm_req <= 1'b0;
		spm_wdata <= ~d; // released data
	endtask
endmodule

/* File: test/fuse_lock_signature_readout_tb.sv */
// testbench: config readout block with an axi4-lite master and a cpu model
`timescale 1ns/10ps
module fuse_lock_signature_readout_tb;
	import cfg_readout_pkg::*;
	// ====================
	// signals
	localparam int PCYC = 20; // shortened timed write
	localparam logic [7:0] ID1 = 8'h1E, ID2 = 8'h2D, ID3 = 8'h3C; // arbitrary identification values
	logic aclk, aresetn, por_n, eeprom_write_active; // clock, resets, eeprom busy
	logic [7:0] s_axi_awaddr, s_axi_araddr; // axi addresses
	logic [31:0] s_axi_wdata, s_axi_rdata; // axi data
	logic [3:0] s_axi_wstrb; // byte strobes
	logic [1:0] s_axi_bresp, s_axi_rresp, prog_kind; // responses, write kind
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready; // write channel
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready; // read channel
	logic load_req, spm_req, load_valid, prog_start, prog_busy, rww_busy_flag; // strobes and flags
	logic [15:0] load_ptr; // pointer
	logic [7:0] flash_rdata, spm_wdata, load_data, fuse_low_byte, fuse_high_byte, extended_fuse_byte, osc_cal_byte;
	logic [5:0] lock_bits, lock_wr_data; // lock bits in and out
	int errors = 0, comparisons = 0, cycles = 0, busy_n = 0; // counters
	cpu_model cpu (.aclk, .load_req, .load_ptr, .flash_rdata, .spm_req, .spm_wdata);
	fuse_lock_signature_readout #(.PROG_CYCLES(PCYC), .SIG_ID1(ID1), .SIG_ID2(ID2), .SIG_ID3(ID3)) dut (.aclk,
		.aresetn, .por_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .load_req, .load_ptr, .flash_rdata, .load_data,
		.load_valid, .spm_req, .spm_wdata, .fuse_low_byte, .fuse_high_byte, .extended_fuse_byte, .lock_bits,
		.osc_cal_byte, .eeprom_write_active, .prog_start, .prog_kind, .lock_wr_data, .prog_busy, .rww_busy_flag);
	// 4 ns clock
	initial begin
		aclk = 1'b0;
		forever #2 aclk = ~aclk;
	end
	// watchdog and busy-length count after each start
	always @(posedge aclk) begin
		cycles <= cycles + 1;
		busy_n <= prog_start ? 0 : busy_n + int'(prog_busy);
		if (cycles == 5000) begin
			errors = errors + 1;
			wrap_up();
		end
	end
	// ====================
	// tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("mismatch at %0t: %s got %0h expected %0h", $time, what, got, exp);
		end
	endtask
	task automatic wrap_up();
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// axi write: release each channel when taken, wait for the response
	task automatic axw(input logic [7:0] a, input logic [31:0] v, output logic [1:0] r);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		r = s_axi_bresp;
	endtask
	// axi read
	task automatic axr(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		v = s_axi_rdata;
		r = s_axi_rresp;
	endtask
	// expected byte of a redirected load
	function automatic logic [7:0] exp_cfg(input logic [7:0] c, input logic [15:0] p);
		case ({c == 8'h21, p})
			{1'b0, 16'h0000}: return fuse_low_byte;
			{1'b0, 16'h0001}: return {2'b11, lock_bits};
			{1'b0, 16'h0002}: return extended_fuse_byte;
			{1'b0, 16'h0003}: return fuse_high_byte;
			{1'b1, 16'h0000}: return ID1;
			{1'b1, 16'h0001}: return osc_cal_byte;
			{1'b1, 16'h0002}: return ID2;
			{1'b1, 16'h0004}: return ID3;
			default: return 8'hFF;
		endcase
	endfunction
	// command, load after d spare cycles, then check auto-clear and normal load
	task automatic cfg_read(input logic [7:0] c, input logic [15:0] p, input int d);
		logic [1:0] r;
		logic [31:0] v;
		axw(8'h00, 32'(c), r);
		repeat (d) @(posedge aclk);
		cpu.load(p);
		@(posedge aclk);
		chk(32'({load_valid, load_data}), 32'({1'b1, exp_cfg(c, p)}), "redirected load");
		axr(8'h00, v, r);
		chk(v, 32'h0, "selects after read");
		cpu.load(p);
		@(posedge aclk);
		chk(32'(load_data), 32'(cpu.last_flash), "normal load");
	endtask
	// ====================
	// main sequence
	initial begin
		logic [31:0] d;
		logic [1:0] r;
		logic [7:0] wcmd [3];
		logic [7:0] pcmd [3];
		wcmd = '{8'h09, 8'h21, 8'h01};
		pcmd = '{8'h03, 8'h05, 8'h09};
		void'($urandom(32'h510A));
		{aresetn, por_n, eeprom_write_active, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 6'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{s_axi_bready, s_axi_rready, s_axi_wstrb} = 6'h3F;
		{fuse_low_byte, fuse_high_byte, extended_fuse_byte, osc_cal_byte, lock_bits} = '1;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		por_n <= 1'b1;
		@(posedge aclk);
		axr(8'h00, d, r);
		chk(d, 32'h0, "control reset value");
		axr(8'h08, d, r);
		chk(32'(r), 32'h2, "unmapped read");
		axw(8'h08, 32'h0, r);
		chk(32'(r), 32'h2, "unmapped write");
		$display("test registers done");
		for (int i = 0; i < 12; i++) begin
			fuse_low_byte <= 8'($urandom);
			fuse_high_byte <= 8'($urandom);
			extended_fuse_byte <= 8'($urandom);
			osc_cal_byte <= 8'($urandom);
			lock_bits <= 6'($urandom);
			@(posedge aclk);
			if (i < 4) cfg_read(8'h09, 16'(i), i % 2);
			else cfg_read(8'h21, 16'(i - 4), i % 2);
		end
		$display("test redirected reads done");
		foreach (wcmd[j]) begin
			axw(8'h00, 32'(wcmd[j]), r);
			repeat (4) @(posedge aclk);
			cpu.load(16'h0001);
			@(posedge aclk);
			chk(32'(load_data), 32'(cpu.last_flash), "load after window");
			axr(8'h00, d, r);
			chk(d, 32'h0, "selects after window");
		end
		$display("test window expiry done");
		eeprom_write_active <= 1'b1;
		axr(8'h04, d, r);
		chk(d, 32'h1, "eeprom status");
		axw(8'h00, 32'h09, r);
		cpu.load(16'h0001);
		@(posedge aclk);
		chk(32'(load_data), 32'(cpu.last_flash), "load during eeprom write");
		axw(8'h00, 32'h03, r);
		cpu.store(8'h00);
		@(posedge aclk);
		chk(32'({prog_start, prog_busy}), 32'h0, "store during eeprom write");
		eeprom_write_active <= 1'b0;
		$display("test eeprom block done");
		foreach (pcmd[k]) begin
			do axr(8'h04, d, r); while (d[0]);
			axw(8'h00, 32'(pcmd[k]), r);
			cpu.store(8'hC5);
			@(posedge aclk);
			chk(32'({prog_start, prog_busy, prog_kind}), 32'({2'b11, 2'(k + 1)}), "write start");
			if (k == 2) chk(32'(lock_wr_data), 32'h05, "lock write data");
			if (k == 0) begin
				aresetn <= 1'b0;
				repeat (2) @(posedge aclk);
				aresetn <= 1'b1;
				@(posedge aclk);
				chk(32'(prog_busy), 32'h1, "write survives reset");
			end
			axr(8'h00, d, r);
			chk(32'(d[6:0] & 7'h41), 32'({k < 2, 6'h01}), "control while busy");
			do axr(8'h00, d, r); while (d[0]);
			chk(32'(busy_n >= PCYC - 1 && busy_n <= PCYC + 2), 32'h1, "write duration");
			if (k < 2) begin
				axw(8'h00, 32'h11, r);
				cpu.store(8'h00);
				repeat (2) @(posedge aclk);
				chk(32'(rww_busy_flag), 32'h0, "rww flag after re-enable");
			end
		end
		$display("test timed writes done");
		wrap_up();
	end
endmodule

/* File: test/readout_checker_assertions.sv */
// checker: port assertions for the config readout block
`timescale 1ns/10ps
module readout_checker
	import cfg_readout_pkg::*;
#(
	parameter int PROG_CYCLES = 20 // timed write length in cycles
) (
	input wire logic aclk, // system clock
	input wire logic aresetn, // functional reset
	input wire logic por_n, // power-on reset
	input wire logic s_axi_bvalid, // write response valid
	input wire logic s_axi_bready, // write response ready
	input wire logic s_axi_arvalid, // read address valid
	input wire logic s_axi_arready, // read address ready
	input wire logic s_axi_rvalid, // read data valid
	input wire logic load_req, // load strobe
	input wire logic load_valid, // loaded byte valid
	input wire logic prog_start, // timed write start
	input wire logic [1:0] prog_kind, // kind of timed write
	input wire logic prog_busy, // timed write in flight
	input wire logic rww_busy_flag // section blocked
);
	// ====================
	// length of the current busy stretch
	logic [31:0] busy_len; // consecutive busy cycles
	always_ff @(posedge aclk) begin
		busy_len <= (por_n && prog_busy) ? busy_len + 32'h1 : 32'h0;
	end
	// ====================
	// assertions
	load_answer_a: assert property (@(posedge aclk) disable iff (!aresetn)
		load_req |=> load_valid) else $error("load gave no answer");
	start_busy_a: assert property (@(posedge aclk) disable iff (!por_n)
		prog_start |-> prog_busy ##1 (!prog_start && prog_busy)) else $error("bad write start");
	busy_len_a: assert property (@(posedge aclk) disable iff (!por_n)
		$fell(prog_busy) |-> busy_len >= PROG_CYCLES && busy_len <= PROG_CYCLES + 3) else $error("write length");
	reset_keep_a: assert property (@(posedge aclk) disable iff (!por_n)
		!aresetn && prog_busy && busy_len < PROG_CYCLES |=> prog_busy) else $error("write aborted by reset");
	rww_set_a: assert property (@(posedge aclk) disable iff (!por_n)
		prog_start && prog_kind != OP_LOCK |-> ##[0:1] rww_busy_flag) else $error("rww flag not set");
	rww_keep_a: assert property (@(posedge aclk) disable iff (!por_n)
		rww_busy_flag && prog_busy |=> rww_busy_flag) else $error("rww flag dropped while busy");
	b_done_a: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("write response repeated");
	r_answer_a: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read response late");
endmodule
bind fuse_lock_signature_readout readout_checker #(.PROG_CYCLES(PROG_CYCLES)) checker_i (.aclk, .aresetn, .por_n,
	.s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .load_req, .load_valid,
	.prog_start, .prog_kind, .prog_busy, .rww_busy_flag);

/* File: verilog/cfg_readout_defs.svh */
// constants: register map, field positions, reset values and timing counts
`ifndef CFG_READOUT_DEFS_SVH
`define CFG_READOUT_DEFS_SVH

// ==========================================================
// register byte offsets
`define CTRL_OFFSET 8'h00
`define STATUS_OFFSET 8'h04

// ==========================================================
// control register field positions
`define ENABLE_BIT 0
`define ERASE_BIT 1
`define PWRITE_BIT 2
`define LFSEL_BIT 3
`define RWWSRE_BIT 4
`define SIGSEL_BIT 5
`define RWWBUSY_BIT 6

// status register field positions
`define EEACT_BIT 0
`define PBUSY_BIT 1

// ==========================================================
// config pointer values
`define PTR_FUSE_LOW 16'h0000
`define PTR_LOCK 16'h0001
`define PTR_FUSE_EXT 16'h0002
`define PTR_FUSE_HIGH 16'h0003
`define PTR_SIG1 16'h0000
`define PTR_CAL 16'h0001
`define PTR_SIG2 16'h0002
`define PTR_SIG3 16'h0004

// ==========================================================
// reset and fill values
`define CTRL_RESET 8'h00
`define LOCK_UNUSED 2'h3
`define RESERVED_BYTE 8'hFF
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// ==========================================================
// timing: redirect windows in cpu cycles, write time in ns
`define LOAD_WINDOW 3'h3
`define STORE_WINDOW 3'h4
`define CLK_PERIOD_NS 4
`define PROG_TIME_MIN_NS 3700000
`define PROG_TIME_MAX_NS 4500000
`define PROG_CYCLES ((`PROG_TIME_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

/* File: verilog/cfg_readout_pkg.sv */
// types shared by the config readout block
package cfg_readout_pkg;
	// engine state
	typedef enum logic [0:0] {
		ENG_IDLE = 1'b0,
		ENG_RUN = 1'b1
	} eng_state_e;
	// kind of timed nonvolatile write in flight
	typedef enum logic [1:0] {
		OP_NONE = 2'b00,
		OP_ERASE = 2'b01,
		OP_PWRITE = 2'b10,
		OP_LOCK = 2'b11
	} prog_op_e;
endpackage

/* File: verilog/fuse_lock_signature_readout.sv */
// config byte readout and self-programming control with axi4-lite registers
`timescale 1ns/10ps
`include "cfg_readout_defs.svh"
module fuse_lock_signature_readout
	import cfg_readout_pkg::*;
#(
	parameter int ADDR_W = 8, // axi address width
	parameter int PROG_CYCLES = `PROG_CYCLES, // timed write length in cycles
	parameter logic [7:0] SIG_ID1 = 8'h5A, // arbitrary identification value
	parameter logic [7:0] SIG_ID2 = 8'h3C, // arbitrary identification value
	parameter logic [7:0] SIG_ID3 = 8'hA5 // arbitrary identification value
) (
	input wire logic aclk, // system clock
	input wire logic aresetn, // functional reset, active low
	input wire logic por_n, // power-on reset for the write engine
	// axi4-lite slave
	input wire logic [ADDR_W-1:0] s_axi_awaddr, // write address
	input wire logic s_axi_awvalid, // write address valid
	output logic s_axi_awready, // write address ready
	input wire logic [31:0] s_axi_wdata, // write data
	input wire logic [3:0] s_axi_wstrb, // write byte strobes
	input wire logic s_axi_wvalid, // write data valid
	output logic s_axi_wready, // write data ready
	output logic [1:0] s_axi_bresp, // write response
	output logic s_axi_bvalid, // write response valid
	input wire logic s_axi_bready, // write response ready
	input wire logic [ADDR_W-1:0] s_axi_araddr, // read address
	input wire logic s_axi_arvalid, // read address valid
	output logic s_axi_arready, // read address ready
	output logic [31:0] s_axi_rdata, // read data
	output logic [1:0] s_axi_rresp, // read response
	output logic s_axi_rvalid, // read data valid
	input wire logic s_axi_rready, // read data ready
	// cpu load and store path
	input wire logic load_req, // load instruction strobe
	input wire logic [15:0] load_ptr, // address pointer
	input wire logic [7:0] flash_rdata, // flash byte at load_ptr
	output logic [7:0] load_data, // loaded byte
	output logic load_valid, // loaded byte valid pulse
	input wire logic spm_req, // store instruction strobe
	input wire logic [7:0] spm_wdata, // low data byte of store
	// nonvolatile values and neighbours
	input wire logic [7:0] fuse_low_byte, // fuse low byte, 0 = programmed
	input wire logic [7:0] fuse_high_byte, // fuse high byte
	input wire logic [7:0] extended_fuse_byte, // extended fuse byte
	input wire logic [5:0] lock_bits, // lock bits 5..0
	input wire logic [7:0] osc_cal_byte, // oscillator calibration byte
	input wire logic eeprom_write_active, // eeprom write in progress
	// write control outputs
	output logic prog_start, // start of a timed write pulse
	output logic [1:0] prog_kind, // kind of timed write
	output logic [5:0] lock_wr_data, // new lock bits for a lock write
	output logic prog_busy, // timed write in flight
	output logic rww_busy_flag // read-while-write section blocked
);
	// ==========================================================
	// parameter check
	generate
		if (ADDR_W < 3 || PROG_CYCLES < 1) begin : g_bad
			$error("fuse_lock_signature_readout: bad parameter");
		end
	endgenerate

	// ==========================================================
	// declarations
	prog_if pif (); // link to the write engine
	logic store_program_enable; // command armed
	logic page_erase_sel; // erase command
	logic page_write_sel; // page write command
	logic lock_fuse_read_select; // lock/fuse redirect
	logic rww_reenable_sel; // rww re-enable command
	logic signature_read_select; // signature redirect
	logic [2:0] win_cnt; // cycles since command write
	logic aw_full; // write address held
	logic w_full; // write data held
	logic [ADDR_W-1:0] aw_addr; // held write address
	logic [31:0] w_data; // held write data
	logic w_lane0; // byte lane 0 strobe held
	logic wr_go; // write commits this cycle
	logic ctrl_wr; // control register write taken
	logic redirect; // load is redirected
	logic store_hit; // store inside the window
	logic [7:0] ctrl_view; // control register read value
	logic [7:0] cfg_byte; // redirected byte

	// ==========================================================
	// helpers
	// which register an address hits: 0 none, 1 ctrl, 2 status
	function automatic logic [1:0] reg_sel(input logic [ADDR_W-1:0] a);
		if (a == ADDR_W'(`CTRL_OFFSET)) begin
			return 2'h1;
		end else if (a == ADDR_W'(`STATUS_OFFSET)) begin
			return 2'h2;
		end
		return 2'h0;
	endfunction

	// byte returned by a redirected load
	function automatic logic [7:0] cfg_read(input logic [15:0] p, input logic sig);
		if (sig) begin
			case (p)
				`PTR_SIG1: return SIG_ID1;
				`PTR_CAL: return osc_cal_byte;
				`PTR_SIG2: return SIG_ID2;
				`PTR_SIG3: return SIG_ID3;
				default: return `RESERVED_BYTE;
			endcase
		end
		// stored bits pass as is: programmed 0, erased 1
		case (p)
			`PTR_FUSE_LOW: return fuse_low_byte;
			`PTR_LOCK: return {`LOCK_UNUSED, lock_bits};
			`PTR_FUSE_EXT: return extended_fuse_byte;
			`PTR_FUSE_HIGH: return fuse_high_byte;
			default: return `RESERVED_BYTE;
		endcase
	endfunction

	// ==========================================================
	// write engine
	prog_timer #(.PROG_CYCLES(PROG_CYCLES)) u_timer (
		.aclk(aclk),
		.por_n(por_n),
		.pif(pif)
	);

	// ==========================================================
	// combinational decode
	always_comb begin
		wr_go = aw_full && w_full && !s_axi_bvalid;
		// writes refused while eeprom busy, while the write engine is busy or while a command is live
		ctrl_wr = wr_go && w_lane0 && (reg_sel(aw_addr) == 2'h1) &&
			!eeprom_write_active && !pif.busy && !store_program_enable;
		redirect = load_req && store_program_enable &&
			(lock_fuse_read_select || signature_read_select) &&
			(win_cnt <= `LOAD_WINDOW);
		store_hit = spm_req && store_program_enable && !signature_read_select &&
			(win_cnt <= `STORE_WINDOW);
		cfg_byte = cfg_read(load_ptr, signature_read_select);
		ctrl_view = 8'h00;
		// enable reads set until the write has ended
		ctrl_view[`ENABLE_BIT] = store_program_enable || pif.busy;
		ctrl_view[`ERASE_BIT] = page_erase_sel;
		ctrl_view[`PWRITE_BIT] = page_write_sel;
		ctrl_view[`LFSEL_BIT] = lock_fuse_read_select;
		ctrl_view[`RWWSRE_BIT] = rww_reenable_sel;
		ctrl_view[`SIGSEL_BIT] = signature_read_select;
		ctrl_view[`RWWBUSY_BIT] = rww_busy_flag;
		pif.start = store_hit && !pif.busy &&
			(page_erase_sel || page_write_sel || lock_fuse_read_select);
	end

	// ==========================================================
	// axi write channels: address and data taken in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full <= 1'b0;
			w_full <= 1'b0;
			aw_addr <= '0;
			w_data <= 32'h0000_0000;
			w_lane0 <= 1'b0;
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin // hold address
				aw_full <= 1'b1;
				aw_addr <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin // hold data
				w_full <= 1'b1;
				w_data <= s_axi_wdata;
				w_lane0 <= s_axi_wstrb[0];
				s_axi_wready <= 1'b0;
			end
			if (wr_go) begin // answer once both halves are in
				aw_full <= 1'b0;
				w_full <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (reg_sel(aw_addr) == 2'h0) ? `RESP_SLVERR : `RESP_OKAY;
			end
			if (s_axi_bvalid && s_axi_bready) begin // reopen channels
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// ==========================================================
	// axi read channel
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `RESP_OKAY;
		end else begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= `RESP_OKAY;
				s_axi_rdata <= 32'h0000_0000;
				case (reg_sel(s_axi_araddr))
					2'h1: s_axi_rdata <= {24'h00_0000, ctrl_view};
					2'h2: s_axi_rdata <= {30'h0000_0000, pif.busy, eeprom_write_active};
					default: s_axi_rresp <= `RESP_SLVERR; // unmapped
				endcase
			end
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

	// ==========================================================
	// command bits, timed window and auto-clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			{signature_read_select, rww_reenable_sel, lock_fuse_read_select} <= 3'h0;
			{page_write_sel, page_erase_sel, store_program_enable} <= 3'h0;
			win_cnt <= 3'h0;
		end else if (ctrl_wr) begin // arm a command, window starts
			store_program_enable <= w_data[`ENABLE_BIT];
			page_erase_sel <= w_data[`ERASE_BIT];
			page_write_sel <= w_data[`PWRITE_BIT];
			lock_fuse_read_select <= w_data[`LFSEL_BIT];
			rww_reenable_sel <= w_data[`RWWSRE_BIT];
			signature_read_select <= w_data[`SIGSEL_BIT];
			win_cnt <= 3'h1;
		end else if (store_program_enable) begin
			if (redirect || store_hit) begin // read or store done
				{signature_read_select, rww_reenable_sel, lock_fuse_read_select} <= 3'h0;
				{page_write_sel, page_erase_sel, store_program_enable} <= 3'h0;
				win_cnt <= 3'h0;
			end else if (((lock_fuse_read_select || signature_read_select) &&
				win_cnt >= `LOAD_WINDOW) || win_cnt >= `STORE_WINDOW) begin
				// window lapsed with no load or store
				{signature_read_select, rww_reenable_sel, lock_fuse_read_select} <= 3'h0;
				{page_write_sel, page_erase_sel, store_program_enable} <= 3'h0;
				win_cnt <= 3'h0;
			end else begin
				win_cnt <= win_cnt + 3'h1;
			end
		end
	end

	// ==========================================================
	// load answer: redirected byte or flash byte, one cycle later
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			load_valid <= 1'b0;
			load_data <= 8'h00;
		end else begin
			load_valid <= load_req;
			if (redirect) begin
				load_data <= cfg_byte;
			end else if (load_req) begin
				load_data <= flash_rdata;
			end
		end
	end

	// ==========================================================
	// write launch, busy and rww flag: on power-on reset only
	always_ff @(posedge aclk) begin
		if (!por_n) begin
			prog_start <= 1'b0;
			prog_kind <= OP_NONE;
			lock_wr_data <= 6'h00;
			prog_busy <= 1'b0;
			rww_busy_flag <= 1'b0;
		end else begin
			prog_start <= pif.start;
			prog_busy <= pif.busy || pif.start;
			if (pif.start) begin
				if (lock_fuse_read_select) begin // lock write
					prog_kind <= OP_LOCK;
					lock_wr_data <= spm_wdata[5:0];
				end else begin // page op blocks the rww section
					prog_kind <= page_erase_sel ? OP_ERASE : OP_PWRITE;
					rww_busy_flag <= 1'b1;
				end
			end else if (store_hit && rww_reenable_sel && !pif.busy) begin
				rww_busy_flag <= 1'b0; // re-enable after the write
			end
		end
	end
endmodule

/* File: verilog/prog_if.sv */
// handshake between the control logic and the timed write engine
`timescale 1ns/10ps
interface prog_if;
	logic start; // one-cycle start of a timed write
	logic busy; // engine is timing a write
	logic done; // one-cycle end of a timed write
	modport ctrl (output start, input busy, input done);
	modport eng (input start, output busy, output done);
endinterface

/* File: verilog/prog_timer.sv */
// timed write engine, survives the functional reset
`timescale 1ns/10ps
`include "cfg_readout_defs.svh"
module prog_timer
	import cfg_readout_pkg::*;
#(
	parameter int PROG_CYCLES = `PROG_CYCLES // write duration in cycles
) (
	input wire logic aclk, // system clock
	input wire logic por_n, // power-on reset, active low, synchronous
	prog_if.eng pif // start, busy and done
);
	// ==========================================================
	// parameter check
	generate
		if (PROG_CYCLES < 1) begin : g_bad
			$error("prog_timer: PROG_CYCLES must be at least 1");
		end
	endgenerate

	eng_state_e state; // idle or timing
	logic [31:0] remain; // cycles left in the write

	// ==========================================================
	// down counter; only power-on reset stops a write in flight
	always_ff @(posedge aclk) begin
		if (!por_n) begin
			state <= ENG_IDLE;
			remain <= 32'h0000_0000;
			pif.done <= 1'b0;
		end else begin
			pif.done <= 1'b0;
			case (state)
				ENG_IDLE: begin
					if (pif.start) begin // write begins
						state <= ENG_RUN;
						remain <= 32'(PROG_CYCLES - 1);
					end
				end
				ENG_RUN: begin
					if (remain == 32'h0000_0000) begin // minimum time reached
						state <= ENG_IDLE;
						pif.done <= 1'b1;
					end else begin
						remain <= remain - 32'h0000_0001;
					end
				end
				default: state <= ENG_IDLE;
			endcase
		end
	end

	// busy straight from the state flop
	assign pif.busy = (state == ENG_RUN);
endmodule
